/* File: verilog/mrsm_pkg.sv */
// Package for the motor reference source multiplexer.
// Assumes one 40 MHz core clock and synchronous active-high reset.
package mrsm_pkg;
  localparam int DUTY_W = 16;
  localparam logic [15:0] DUTY_FULL = 16'hFFFF;
  localparam int ADC_W = 12;
  localparam int CNT_W = 24;
  localparam int TGT_W = 16;
  localparam logic [1:0] SRC_ANALOG = 2'h0;
  localparam logic [1:0] SRC_PWM = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;
  localparam logic [1:0] SRC_FREQ = 2'h3;
  localparam logic LOOP_SPEED = 1'h0;
  localparam logic LOOP_CURRENT = 1'h1;
  localparam logic [1:0] PROFILE_DIRECT = 2'h0;
  localparam real CLOCK_MHZ = 40.0;
  // PWM range selections, timeout per range in microseconds
  localparam real RANGE_LOW_US = 20000.0;
  localparam real RANGE_HIGH_US = 2000.0;
  localparam int RANGE_LOW_CYC = int'(RANGE_LOW_US * CLOCK_MHZ);
  localparam int RANGE_HIGH_CYC = int'(RANGE_HIGH_US * CLOCK_MHZ);
  localparam logic [CNT_W-1:0] COUNT_MAX = 24'hFFFFFF;
  typedef enum {MRSM_RUN, MRSM_STANDBY, MRSM_SLEEP} mrsm_state_type;
endpackage

/* File: verilog/mrsm_meas_if.sv */
// Carrier between the pin measurement unit and the multiplexer core.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
`default_nettype none
interface mrsm_meas_if;
  logic done;
  logic [mrsm_pkg::CNT_W-1:0] highCount;
  logic [mrsm_pkg::CNT_W-1:0] periodCount;
  logic timedOut;
  modport meas (output done, output highCount, output periodCount,
    output timedOut);
  modport core (input done, input highCount, input periodCount,
    input timedOut);
endinterface
`default_nettype wire

/* File: verilog/mrsm_pin_meter.sv */
// Measures high time and period of the command pin, edge to edge.
// Assumes the pin is already synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module mrsm_pin_meter (
  input wire logic clock,
  input wire logic srst,
  input wire logic cmdPin,
  input wire logic rangeSelect,
  mrsm_meas_if.meas meas
);
  logic pinLast;
  logic [mrsm_pkg::CNT_W-1:0] periodCnt;
  logic [mrsm_pkg::CNT_W-1:0] highCnt;
  logic [mrsm_pkg::CNT_W-1:0] limit;
  logic rise;

  assign rise = cmdPin && !pinLast;
  // Range select only moves the timeout, never the motor PWM rate
  assign limit = rangeSelect ?
    mrsm_pkg::CNT_W'(mrsm_pkg::RANGE_HIGH_CYC) :
    mrsm_pkg::CNT_W'(mrsm_pkg::RANGE_LOW_CYC);

  always_ff @(posedge clock) begin
    if (srst) begin
      pinLast <= 1'b0;
    end else begin
      pinLast <= cmdPin;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || rise) begin
      periodCnt <= '0;
      highCnt <= '0;
    end else if (periodCnt < limit) begin
      periodCnt <= periodCnt + 1'b1;
      highCnt <= highCnt + {{(mrsm_pkg::CNT_W-1){1'b0}}, cmdPin};
    end
  end

  // A stuck pin still yields a result, so 0% and 100% are seen
  always_ff @(posedge clock) begin
    if (srst) begin
      meas.done <= 1'b0;
      meas.highCount <= '0;
      meas.periodCount <= '0;
      meas.timedOut <= 1'b0;
    end else begin
      meas.done <= rise || (periodCnt == limit - 1'b1);
      if (rise) begin
        meas.highCount <= highCnt;
        meas.periodCount <= periodCnt + 1'b1;
        meas.timedOut <= 1'b0;
      end else if (periodCnt == limit - 1'b1) begin
        meas.highCount <= cmdPin ? limit : '0;
        meas.periodCount <= limit;
        meas.timedOut <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/mrsm_mux.sv */
// Motor reference source multiplexer: picks the input reference,
// maps it to a duty command and a target, tracks standby and sleep.
// Assumes analog samples arrive with a valid strobe, pin synchronous.
//
// Overview of operation
// - Loop select 0 regulates speed via PI
// - Loop select 1 regulates torque current via PI
// - Two-bit selector: analog, PWM, serial, frequency
// - Analog: zero below entry, linear, clamp full
// - PWM: duty 0-100%, standby thresholds, linear
// - PWM input range selectable, independent of outputs
// - Serial mode takes duty from setpoint register
// - Serial: sleep on low pin after zero dwell
// - Serial: wake above sleep exit, use setpoint
// - Serial: standby when setpoint at/below threshold
// - Frequency: zero below entry, linear to maximum
// - Frequency above maximum clamps duty to 100%
// - Zero reference stops motor under any curve
// - Direct curve: target is duty times limit
`timescale 1ns/1ps
`default_nettype none
module mrsm_mux #(
  parameter logic [23:0] DORMANCY_CYCLES = 24'h009C40
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0] sourceSelect,
  input wire logic closed_loop_select,
  input wire logic [1:0] profileSelect,
  input wire logic rangeSelect,
  input wire logic cmdPin,
  input wire logic [11:0] analogSample,
  input wire logic analogValid,
  input wire logic [11:0] analog_full_scale_level,
  input wire logic [15:0] standby_entry_level,
  input wire logic [15:0] standby_exit_level,
  input wire logic [11:0] sleep_entry_level,
  input wire logic [11:0] sleep_exit_level,
  input wire logic [23:0] maxInputPeriod,
  input wire logic [15:0] serialSetpoint,
  input wire logic [15:0] serial_standby_threshold,
  input wire logic [15:0] topRate,
  input wire logic [15:0] current_limit,
  output logic [15:0] dutyCommand,
  output logic dutyValid,
  output logic [15:0] speedTarget,
  output logic [15:0] currentTarget,
  output logic speedLoopActive,
  output logic currentLoopActive,
  output logic motorRun,
  output logic standbyState,
  output logic sleepState
);
  mrsm_meas_if meas ();
  mrsm_pin_meter u_meter (
    .clock(clock),
    .srst(srst),
    .cmdPin(cmdPin),
    .rangeSelect(rangeSelect),
    .meas(meas.meas)
  );

  mrsm_pkg::mrsm_state_type state;
  mrsm_pkg::mrsm_state_type next_state;
  logic [15:0] level;
  logic [15:0] span;
  logic [15:0] fullLevel;
  logic sampleNow;
  logic [15:0] next_duty;
  logic [23:0] zeroDwell;
  logic dwellDone;
  logic [11:0] pinLevel;

  // Scale x in [0,top] onto a full-range fraction, clamped
  function automatic logic [15:0] ratio(input logic [23:0] x,
                                        input logic [23:0] top);
    logic [39:0] num;
    logic [39:0] q;
    num = {x, 16'h0000};
    q = (top == 24'h000000) ? 40'h0000000000 : num / {16'h0000, top};
    if (x >= top) begin
      ratio = mrsm_pkg::DUTY_FULL;
    end else begin
      ratio = q[15:0];
    end
  endfunction

  function automatic logic [15:0] scaleBy(input logic [15:0] d,
                                          input logic [15:0] k);
    logic [31:0] p;
    p = d * k;
    scaleBy = p[31:16];
  endfunction

  // Normalised input level and full scale for the chosen source
  always_comb begin
    level = '0;
    fullLevel = mrsm_pkg::DUTY_FULL;
    sampleNow = 1'b0;
    case (sourceSelect)
      mrsm_pkg::SRC_ANALOG: begin
        level = {analogSample, 4'h0};
        fullLevel = {analog_full_scale_level, 4'h0};
        sampleNow = analogValid;
      end
      mrsm_pkg::SRC_PWM: begin
        level = ratio(meas.highCount, meas.periodCount);
        sampleNow = meas.done;
      end
      mrsm_pkg::SRC_SERIAL: begin
        level = serialSetpoint;
        sampleNow = 1'b1;
      end
      default: begin
        // Frequency as fraction of maximum: maxPeriod / period
        level = (meas.timedOut || meas.periodCount == '0) ? 16'h0000 :
          ratio(maxInputPeriod, meas.periodCount);
        sampleNow = meas.done;
      end
    endcase
  end

  assign span = (fullLevel > standby_exit_level) ?
    16'(fullLevel - standby_exit_level) : 16'h0001;

  // Standby hysteresis: off at/below entry, on at/above exit
  always_comb begin
    next_duty = dutyCommand;
    if (sourceSelect == mrsm_pkg::SRC_SERIAL) begin
      if (serialSetpoint <= serial_standby_threshold) begin
        next_duty = '0;
      end else begin
        next_duty = serialSetpoint;
      end
    end else if (level == '0 || level <= standby_entry_level) begin
      next_duty = '0;
    end else if (level >= fullLevel) begin
      next_duty = mrsm_pkg::DUTY_FULL;
    end else if (level >= standby_exit_level) begin
      next_duty = ratio({8'h00, 16'(level - standby_exit_level)},
                        {8'h00, span});
    end else if (!motorRun) begin
      next_duty = '0;
    end else begin
      next_duty = dutyCommand;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dutyCommand <= '0;
      dutyValid <= 1'b0;
    end else begin
      dutyValid <= sampleNow;
      if (sleepState) begin
        dutyCommand <= '0;
      end else if (sampleNow) begin
        dutyCommand <= next_duty;
      end
    end
  end

  assign motorRun = (dutyCommand != '0);

  // Zero-setpoint dwell, set longer than lowest-duty low time by user
  always_ff @(posedge clock) begin
    if (srst || serialSetpoint != '0) begin
      zeroDwell <= '0;
    end else if (!dwellDone) begin
      zeroDwell <= zeroDwell + 1'b1;
    end
  end
  assign dwellDone = (zeroDwell > DORMANCY_CYCLES);

  // Sample bus is only meaningful on its strobe, so keep the last one
  always_ff @(posedge clock) begin
    if (srst) begin
      pinLevel <= '0;
    end else if (analogValid) begin
      pinLevel <= analogSample;
    end
  end

  // Pin level for sleep uses the held analog sample of the command pin
  always_comb begin
    next_state = state;
    case (state)
      mrsm_pkg::MRSM_SLEEP: begin
        if (sourceSelect != mrsm_pkg::SRC_SERIAL ||
            pinLevel > sleep_exit_level) begin
          next_state = mrsm_pkg::MRSM_STANDBY;
        end
      end
      default: begin
        if (sourceSelect == mrsm_pkg::SRC_SERIAL && dwellDone &&
            pinLevel < sleep_entry_level) begin
          next_state = mrsm_pkg::MRSM_SLEEP;
        end else if (motorRun) begin
          next_state = mrsm_pkg::MRSM_RUN;
        end else begin
          next_state = mrsm_pkg::MRSM_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= mrsm_pkg::MRSM_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  assign standbyState = (state == mrsm_pkg::MRSM_STANDBY);
  assign sleepState = (state == mrsm_pkg::MRSM_SLEEP);

  // Only the direct curve is built; other profiles hold target at zero
  always_ff @(posedge clock) begin
    if (srst) begin
      speedTarget <= '0;
      currentTarget <= '0;
      speedLoopActive <= 1'b0;
      currentLoopActive <= 1'b0;
    end else begin
      speedLoopActive <= motorRun &&
        (closed_loop_select == mrsm_pkg::LOOP_SPEED);
      currentLoopActive <= motorRun &&
        (closed_loop_select == mrsm_pkg::LOOP_CURRENT);
      if (profileSelect == mrsm_pkg::PROFILE_DIRECT) begin
        speedTarget <= (closed_loop_select == mrsm_pkg::LOOP_SPEED) ?
          scaleBy(dutyCommand, topRate) : 16'h0000;
        currentTarget <= (closed_loop_select == mrsm_pkg::LOOP_CURRENT) ?
          scaleBy(dutyCommand, current_limit) : 16'h0000;
      end else begin
        speedTarget <= '0;
        currentTarget <= '0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/mrsm_cmd_source.sv */
// Far-side model: drives the command pin and posts ADC samples.
// Assumes one core clock; pin sits low while no waveform is on.
`timescale 1ns/1ps
`default_nettype none
module mrsm_cmd_source (
  input wire logic clock,
  input wire logic pwmOn,
  input wire logic [9:0] highCycles,
  input wire logic [9:0] periodCycles,
  input wire logic [11:0] level,
  output logic cmdPin = 1'b0,
  output logic [11:0] analogSample = 12'h000,
  output logic analogValid = 1'b0
);
  logic [9:0] phase = 10'h000;
  logic [3:0] tick = 4'h0;
  always @(posedge clock) begin
    phase <= (phase + 10'h001 >= periodCycles) ? 10'h000 : phase + 10'h001;
    tick <= tick + 4'h1;
    // Pull-down holds the pin low when off
    cmdPin <= pwmOn && phase < highCycles;
    analogValid <= tick == 4'hF;
    // Between samples the bus shows junk, not the last value
    analogSample <= (tick == 4'hF) ? level : ~level;
  end
endmodule
`default_nettype wire

/* File: sim/mrsm_mux_checker.sv */
// Port assertions for the reference source multiplexer.
// Assumes binding into mrsm_mux, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module mrsm_mux_checker #(
  parameter logic [23:0] DORMANCY_CYCLES = 24'h009C40
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0] sourceSelect,
  input wire logic closed_loop_select,
  input wire logic [1:0] profileSelect,
  input wire logic [11:0] analogSample,
  input wire logic analogValid,
  input wire logic [11:0] analog_full_scale_level,
  input wire logic [15:0] standby_entry_level,
  input wire logic [15:0] serialSetpoint,
  input wire logic [15:0] serial_standby_threshold,
  input wire logic [15:0] topRate,
  input wire logic [15:0] dutyCommand,
  input wire logic dutyValid,
  input wire logic [15:0] speedTarget,
  input wire logic speedLoopActive,
  input wire logic currentLoopActive,
  input wire logic motorRun,
  input wire logic sleepState
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  function automatic logic [15:0] scale(input logic [15:0] d,
    input logic [15:0] k);
    logic [31:0] p;
    p = d * k;
    return p[31:16];
  endfunction
  chk_sleep_zero: assert property (sleepState |-> dutyCommand == 16'h0000)
    else $error("duty nonzero in sleep");
  chk_run_flag: assert property (motorRun == (dutyCommand != 16'h0000))
    else $error("run flag wrong");
  chk_loops_exclusive: assert property (!(speedLoopActive && currentLoopActive))
    else $error("both loops active");
  chk_current_cause: assert property (currentLoopActive |-> $past(closed_loop_select))
    else $error("current loop unselected");
  chk_serial_standby: assert property ((sourceSelect == mrsm_pkg::SRC_SERIAL
    && serialSetpoint <= serial_standby_threshold) |=> dutyCommand == 16'h0000)
    else $error("serial standby duty");
  chk_serial_follow: assert property ((sourceSelect == mrsm_pkg::SRC_SERIAL
    && serialSetpoint > serial_standby_threshold && !sleepState)
    |=> dutyCommand == $past(serialSetpoint)) else $error("serial duty");
  chk_analog_clamp: assert property ((analogValid && !sleepState
    && sourceSelect == mrsm_pkg::SRC_ANALOG
    && analogSample > analog_full_scale_level)
    |=> dutyValid && dutyCommand == mrsm_pkg::DUTY_FULL) else $error("clamp");
  chk_analog_stop: assert property ((analogValid
    && sourceSelect == mrsm_pkg::SRC_ANALOG
    && {analogSample, 4'h0} <= standby_entry_level)
    |=> dutyValid && dutyCommand == 16'h0000) else $error("analog stop");
  chk_speed_target: assert property ((!closed_loop_select
    && !$past(closed_loop_select)
    && profileSelect == mrsm_pkg::PROFILE_DIRECT)
    |=> speedTarget == scale($past(dutyCommand), $past(topRate)))
    else $error("speed target");
  cover property (sleepState);
  cover property (dutyValid && dutyCommand == mrsm_pkg::DUTY_FULL);
  cover property (currentLoopActive && motorRun);
endmodule
bind mrsm_mux mrsm_mux_checker #(.DORMANCY_CYCLES(DORMANCY_CYCLES))
  mrsm_mux_checker_inst (.*);
`default_nettype wire

/* File: sim/mrsm_mux_tb.sv */
// Self-checking bench for the reference source multiplexer.
// Assumes the command source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module mrsm_mux_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [1:0] sourceSelect = 2'h0;
  logic [1:0] profileSelect = 2'h0;
  logic closed_loop_select = 1'b0;
  logic rangeSelect = 1'b0;
  logic pwmOn = 1'b0;
  logic cmdPin, analogValid, dutyValid, speedLoopActive, currentLoopActive;
  logic motorRun, standbyState, sleepState;
  logic [9:0] highCycles = 10'h001;
  logic [9:0] periodCycles = 10'h010;
  logic [11:0] level = 12'h000;
  logic [11:0] analogSample;
  logic [15:0] serialSetpoint = 16'h0000;
  logic [15:0] serial_standby_threshold = 16'h0100;
  logic [15:0] topRate = 16'h3000;
  logic [15:0] current_limit = 16'h2000;
  logic [15:0] standby_exit_level = 16'h2000;
  logic [23:0] maxInputPeriod = 24'h000010;
  logic [15:0] dutyCommand, speedTarget, currentTarget;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  always #12.5 clock = ~clock;
  mrsm_cmd_source mrsm_cmd_source_inst (.clock, .pwmOn, .highCycles,
    .periodCycles, .level, .cmdPin, .analogSample, .analogValid);
  // Dormancy well above the longest pin low time used here
  mrsm_mux #(.DORMANCY_CYCLES(24'h000400)) mrsm_mux_inst (.clock, .srst,
    .sourceSelect, .closed_loop_select, .profileSelect, .rangeSelect,
    .cmdPin, .analogSample, .analogValid,
    .analog_full_scale_level(12'h800), .standby_entry_level(16'h1000),
    .standby_exit_level, .sleep_entry_level(12'h100),
    .sleep_exit_level(12'h400), .maxInputPeriod,
    .serialSetpoint, .serial_standby_threshold, .topRate,
    .current_limit, .dutyCommand, .dutyValid, .speedTarget,
    .currentTarget, .speedLoopActive, .currentLoopActive, .motorRun,
    .standbyState, .sleepState);
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic t_analog();
    @(posedge clock);
    level <= 12'hFFF;
    settle(40);
    chk("analog full", mrsm_pkg::DUTY_FULL, dutyCommand);
    chk("speed target", 16'h2FFF, speedTarget);
    chk("speed loop", 16'h0001, {15'h0, speedLoopActive});
    @(posedge clock);
    topRate <= 16'h6000;
    settle(4);
    chk("speed target rate", 16'h5FFF, speedTarget);
    @(posedge clock);
    topRate <= 16'h3000;
    @(posedge clock);
    level <= 12'h180;
    settle(40);
    chk("held run", 16'h0001, {15'h0, motorRun});
    @(posedge clock);
    level <= 12'h100;
    settle(40);
    chk("analog stop", 16'h0000, dutyCommand);
    chk("stopped", 16'h0000, {15'h0, motorRun});
    @(posedge clock);
    level <= 12'h180;
    settle(40);
    chk("held stop", 16'h0000, dutyCommand);
    $display("analog test done");
  endtask
  task automatic t_current();
    @(posedge clock);
    closed_loop_select <= 1'b1;
    level <= 12'hFFF;
    settle(40);
    chk("current target", 16'h1FFF, currentTarget);
    @(posedge clock);
    current_limit <= 16'h4000;
    settle(4);
    chk("current limit", 16'h3FFF, currentTarget);
    @(posedge clock);
    current_limit <= 16'h2000;
    chk("speed loop off", 16'h0000, {15'h0, speedLoopActive});
    @(posedge clock);
    profileSelect <= 2'h1;
    settle(4);
    chk("other curve", 16'h0000, currentTarget);
    @(posedge clock);
    profileSelect <= mrsm_pkg::PROFILE_DIRECT;
    closed_loop_select <= 1'b0;
    $display("current test done");
  endtask
  task automatic t_pin();
    @(posedge clock);
    sourceSelect <= 2'h1;
    rangeSelect <= 1'b1;
    pwmOn <= 1'b1;
    settle(100);
    chk("pwm low", 16'h0000, dutyCommand);
    @(posedge clock);
    highCycles <= 10'h00F;
    settle(100);
    chk("pwm high", 16'h0001, {15'h0, dutyCommand > 16'h8000});
    @(posedge clock);
    sourceSelect <= 2'h3;
    highCycles <= 10'h004;
    periodCycles <= 10'h008;
    settle(100);
    chk("freq clamp", mrsm_pkg::DUTY_FULL, dutyCommand);
    @(posedge clock);
    highCycles <= 10'h1F4;
    periodCycles <= 10'h3E8;
    settle(3000);
    chk("freq stop", 16'h0000, dutyCommand);
    $display("pin test done");
  endtask
  task automatic t_serial();
    @(posedge clock);
    sourceSelect <= 2'h2;
    pwmOn <= 1'b0;
    serialSetpoint <= 16'h1234;
    settle(40);
    chk("serial duty", 16'h1234, dutyCommand);
    @(posedge clock);
    serial_standby_threshold <= 16'h1234;
    settle(4);
    chk("standby", 16'h0001, {15'h0, standbyState});
    @(posedge clock);
    serial_standby_threshold <= 16'h0100;
    serialSetpoint <= 16'h0000;
    level <= 12'h010;
    settle(1200);
    chk("sleep", 16'h0001, {15'h0, sleepState});
    @(posedge clock);
    level <= 12'hFFF;
    settle(40);
    chk("awake", 16'h0000, {15'h0, sleepState});
    @(posedge clock);
    serialSetpoint <= 16'h1234;
    settle(4);
    chk("resume", 16'h1234, dutyCommand);
    $display("serial test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    t_analog();
    t_current();
    t_pin();
    t_serial();
    tally_and_finish();
  end
endmodule
`default_nettype wire
